// ### verilog/pdu_pkg.sv
// Purpose: constants and types for the peripheral disable unit
// Assumes: axi4-lite register bus, 32-bit data, 16-bit control registers
// Notes: register map and bit positions of the three disable registers
`default_nettype none

package pdu_pkg;

	// ****************************************************************
	// bus geometry
	// ****************************************************************
	localparam int PDU_ADDR_W = 4;
	localparam int PDU_DATA_W = 32;
	localparam int PDU_REG_W = 16;
	localparam int PDU_STRB_W = PDU_DATA_W / 8;

	// ****************************************************************
	// register map (byte addresses)
	// ****************************************************************
	localparam logic [PDU_ADDR_W-1:0] PDU_OFS_CTRL_1 = 4'h0;
	localparam logic [PDU_ADDR_W-1:0] PDU_OFS_CTRL_2 = 4'h4;
	localparam logic [PDU_ADDR_W-1:0] PDU_OFS_CTRL_3 = 4'h8;

	// ****************************************************************
	// responses
	// ****************************************************************
	localparam logic [1:0] PDU_RESP_OKAY = 2'h0;
	localparam logic [1:0] PDU_RESP_SLVERR = 2'h2;

	// ****************************************************************
	// reset value and implemented bits
	// ****************************************************************
	localparam logic [PDU_REG_W-1:0] PDU_CTRL_RST = 16'h0000;
	localparam logic [PDU_REG_W-1:0] PDU_IMPL_1 = 16'hf9ff;
	localparam logic [PDU_REG_W-1:0] PDU_IMPL_2 = 16'hffff;
	localparam logic [PDU_REG_W-1:0] PDU_IMPL_3 = 16'hf003;

	// ****************************************************************
	// bit positions, periph_disable_ctrl_1
	// ****************************************************************
	localparam int PDU_B1_TIMER5 = 15;
	localparam int PDU_B1_TIMER4 = 14;
	localparam int PDU_B1_TIMER3 = 13;
	localparam int PDU_B1_TIMER2 = 12;
	localparam int PDU_B1_TIMER1 = 11;
	localparam int PDU_B1_CODEC = 8;
	localparam int PDU_B1_I2C1 = 7;
	localparam int PDU_B1_UART2 = 6;
	localparam int PDU_B1_UART1 = 5;
	localparam int PDU_B1_SPI2 = 4;
	localparam int PDU_B1_SPI1 = 3;
	localparam int PDU_B1_CAN2 = 2;
	localparam int PDU_B1_CAN1 = 1;
	localparam int PDU_B1_ADC1 = 0;

	// ****************************************************************
	// bit positions, periph_disable_ctrl_2 and _3
	// ****************************************************************
	localparam int PDU_B2_CAPTURE_LSB = 8;
	localparam int PDU_B2_COMPARE_LSB = 0;
	localparam int PDU_B3_TIMER6_LSB = 12;
	localparam int PDU_B3_I2C2 = 1;
	localparam int PDU_B3_ADC2 = 0;

	// ****************************************************************
	// block state
	// ****************************************************************
	typedef struct packed {
		logic [PDU_REG_W-1:0] ctrl1;
		logic [PDU_REG_W-1:0] ctrl2;
		logic [PDU_REG_W-1:0] ctrl3;
		logic [PDU_REG_W-1:0] en1;
		logic [PDU_REG_W-1:0] en2;
		logic [PDU_REG_W-1:0] en3;
		logic awready;
		logic wready;
		logic aw_full;
		logic w_full;
		logic [PDU_ADDR_W-1:0] awaddr;
		logic [PDU_DATA_W-1:0] wdata;
		logic [PDU_STRB_W-1:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [PDU_DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} pdu_state_t;

endpackage

`default_nettype wire

// ### verilog/pdu_top.sv
// Purpose: peripheral disable unit, three disable registers over axi4-lite
// Assumes: one clock, synchronous active-high reset, one instruction cycle = one clk
// Notes: enables feed peripheral clock gates and register-access blocks
//
// Contract
// R1: a set disable bit stops every clock of that peripheral; clear lets it run.
// R2: a disabled peripheral ignores register writes; its reads are undefined.
// R3: enabled only when bit clear and peripheral present in this variant.
// R4: all disable bits read zero after reset, present peripherals start enabled.
// R5: setting a bit disables its peripheral one instruction cycle later.
// R6: clearing a bit enables its peripheral one instruction cycle later.
// R7: register 1 bits 15..11 disable timers 5 down to 1.
// R8: register 1 bit 8 disables the codec interface; bits 10..9 read zero.
// R9: register 1 bits 7..0: i2c1, uart2, uart1, spi2, spi1, can2, can1, adc1.
// R10: register 2 bits 15..8 disable input captures 8 down to 1.
// R11: register 2 bits 7..0 disable output compares 8 down to 1.
// R12: register 3 bits 15..12 disable timers 9 down to 6.
// R13: register 3 bit 1 i2c2, bit 0 adc2; bits 11..2 read zero.
// R14: each bit drives a glitch-free clock gate and access block; reads return writes.
`timescale 1ns/1ps
`default_nettype none

module pdu_top
	import pdu_pkg::*;
#(
	parameter logic [PDU_REG_W-1:0] PRESENT_1 = PDU_IMPL_1,
	parameter logic [PDU_REG_W-1:0] PRESENT_2 = PDU_IMPL_2,
	parameter logic [PDU_REG_W-1:0] PRESENT_3 = PDU_IMPL_3
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [PDU_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [PDU_DATA_W-1:0] s_axi_wdata,
	input wire logic [PDU_STRB_W-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [PDU_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [PDU_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic timer5_on,
	output logic timer4_on,
	output logic timer3_on,
	output logic timer2_on,
	output logic timer1_on,
	output logic codec_if_on,
	output logic i2c_first_on,
	output logic uart_second_on,
	output logic uart_first_on,
	output logic spi_second_on,
	output logic spi_first_on,
	output logic can_second_on,
	output logic can_first_on,
	output logic adc_first_on,
	output logic [7:0] capture_on,
	output logic [7:0] compare_on,
	output logic [3:0] timer6_9_on,
	output logic i2c_second_on,
	output logic adc_second_on
);

	// ****************************************************************
	// elaboration checks
	// ****************************************************************
	generate
		if ((PRESENT_1 & ~PDU_IMPL_1) != 16'h0000) begin : g_chk1
			$error("PRESENT_1 marks an unimplemented bit");
		end
		if ((PRESENT_2 & ~PDU_IMPL_2) != 16'h0000) begin : g_chk2
			$error("PRESENT_2 marks an unimplemented bit");
		end
		if ((PRESENT_3 & ~PDU_IMPL_3) != 16'h0000) begin : g_chk3
			$error("PRESENT_3 marks an unimplemented bit");
		end
	endgenerate

	// ****************************************************************
	// reset value of the state
	// ****************************************************************
	localparam pdu_state_t PDU_STATE_RST = '{
		ctrl1: PDU_CTRL_RST,
		ctrl2: PDU_CTRL_RST,
		ctrl3: PDU_CTRL_RST,
		en1: PRESENT_1,
		en2: PRESENT_2,
		en3: PRESENT_3,
		awready: 1'b1,
		wready: 1'b1,
		aw_full: 1'b0,
		w_full: 1'b0,
		awaddr: '0,
		wdata: '0,
		wstrb: '0,
		bvalid: 1'b0,
		bresp: PDU_RESP_OKAY,
		arready: 1'b1,
		rvalid: 1'b0,
		rdata: '0,
		rresp: PDU_RESP_OKAY
	};

	pdu_state_t st_r;
	pdu_state_t st_nxt;
	logic [PDU_REG_W-1:0] wr_val;
	logic [PDU_REG_W-1:0] rd_val;
	logic rd_hit;
	logic wr_hit;

	// ****************************************************************
	// write merge by byte strobes
	// ****************************************************************
	function automatic logic [PDU_REG_W-1:0] pdu_merge(
		input logic [PDU_REG_W-1:0] old_v,
		input logic [PDU_DATA_W-1:0] data,
		input logic [PDU_STRB_W-1:0] strb,
		input logic [PDU_REG_W-1:0] impl
	);
		logic [PDU_REG_W-1:0] v;
		v = old_v;
		if (strb[0]) begin
			v[7:0] = data[7:0];
		end
		if (strb[1]) begin
			v[15:8] = data[15:8];
		end
		return v & impl; // R8 R13
	endfunction

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		st_nxt = st_r;
		wr_val = '0;
		rd_val = '0;
		rd_hit = 1'b1;
		wr_hit = 1'b1;

		// write address and data, taken in either order
		if (s_axi_awvalid && st_r.awready) begin
			st_nxt.awaddr = s_axi_awaddr;
			st_nxt.aw_full = 1'b1;
			st_nxt.awready = 1'b0;
		end
		if (s_axi_wvalid && st_r.wready) begin
			st_nxt.wdata = s_axi_wdata;
			st_nxt.wstrb = s_axi_wstrb;
			st_nxt.w_full = 1'b1;
			st_nxt.wready = 1'b0;
		end

		// commit once both halves are held
		if (st_r.aw_full && st_r.w_full && !st_r.bvalid) begin
			case (st_r.awaddr)
				PDU_OFS_CTRL_1: begin
					wr_val = pdu_merge(st_r.ctrl1, st_r.wdata, st_r.wstrb, PDU_IMPL_1);
					st_nxt.ctrl1 = wr_val; // R7 R8 R9 R14
				end
				PDU_OFS_CTRL_2: begin
					wr_val = pdu_merge(st_r.ctrl2, st_r.wdata, st_r.wstrb, PDU_IMPL_2);
					st_nxt.ctrl2 = wr_val; // R10 R11 R14
				end
				PDU_OFS_CTRL_3: begin
					wr_val = pdu_merge(st_r.ctrl3, st_r.wdata, st_r.wstrb, PDU_IMPL_3);
					st_nxt.ctrl3 = wr_val; // R12 R13 R14
				end
				default: begin
					wr_hit = 1'b0;
				end
			endcase
			st_nxt.aw_full = 1'b0;
			st_nxt.w_full = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = wr_hit ? PDU_RESP_OKAY : PDU_RESP_SLVERR;
		end

		// write response
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
			st_nxt.awready = 1'b1;
			st_nxt.wready = 1'b1;
		end

		// read
		if (s_axi_arvalid && st_r.arready) begin
			case (s_axi_araddr)
				PDU_OFS_CTRL_1: begin
					rd_val = st_r.ctrl1; // R8 R14
				end
				PDU_OFS_CTRL_2: begin
					rd_val = st_r.ctrl2; // R14
				end
				PDU_OFS_CTRL_3: begin
					rd_val = st_r.ctrl3; // R13 R14
				end
				default: begin
					rd_hit = 1'b0;
				end
			endcase
			st_nxt.arready = 1'b0;
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = {{(PDU_DATA_W-PDU_REG_W){1'b0}}, rd_val};
			st_nxt.rresp = rd_hit ? PDU_RESP_OKAY : PDU_RESP_SLVERR;
		end
		if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
			st_nxt.arready = 1'b1;
		end

		// enables follow the registers one cycle later
		st_nxt.en1 = ~st_r.ctrl1 & PRESENT_1; // R1 R3 R5 R6
		st_nxt.en2 = ~st_r.ctrl2 & PRESENT_2; // R1 R3 R5 R6
		st_nxt.en3 = ~st_r.ctrl3 & PRESENT_3; // R1 R3 R5 R6
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_r <= PDU_STATE_RST; // R4
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	// each enable gates a glitch-free clock cell and the register port
	assign s_axi_awready = st_r.awready;
	assign s_axi_wready = st_r.wready;
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_arready = st_r.arready;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rdata = st_r.rdata;
	assign s_axi_rresp = st_r.rresp;
	assign timer5_on = st_r.en1[PDU_B1_TIMER5]; // R7 R14
	assign timer4_on = st_r.en1[PDU_B1_TIMER4]; // R7
	assign timer3_on = st_r.en1[PDU_B1_TIMER3]; // R7
	assign timer2_on = st_r.en1[PDU_B1_TIMER2]; // R7
	assign timer1_on = st_r.en1[PDU_B1_TIMER1]; // R7
	assign codec_if_on = st_r.en1[PDU_B1_CODEC]; // R8
	assign i2c_first_on = st_r.en1[PDU_B1_I2C1]; // R9
	assign uart_second_on = st_r.en1[PDU_B1_UART2]; // R9
	assign uart_first_on = st_r.en1[PDU_B1_UART1]; // R9
	assign spi_second_on = st_r.en1[PDU_B1_SPI2]; // R9
	assign spi_first_on = st_r.en1[PDU_B1_SPI1]; // R9
	assign can_second_on = st_r.en1[PDU_B1_CAN2]; // R9
	assign can_first_on = st_r.en1[PDU_B1_CAN1]; // R9
	assign adc_first_on = st_r.en1[PDU_B1_ADC1]; // R9
	assign capture_on = st_r.en2[PDU_B2_CAPTURE_LSB +: 8]; // R10 R2
	assign compare_on = st_r.en2[PDU_B2_COMPARE_LSB +: 8]; // R11 R2
	assign timer6_9_on = st_r.en3[PDU_B3_TIMER6_LSB +: 4]; // R12
	assign i2c_second_on = st_r.en3[PDU_B3_I2C2]; // R13
	assign adc_second_on = st_r.en3[PDU_B3_ADC2]; // R13

	logic unused_prot;
	assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

endmodule // pdu_top

`default_nettype wire

// ### verification/pdu_props.sv
// Purpose: port checks of the peripheral disable unit
// Assumes: default present masks, all peripherals present
// Notes: bound to pdu_top
`timescale 1ns/1ps
`default_nettype none
module pdu_props
	import pdu_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [PDU_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [PDU_DATA_W-1:0] s_axi_rdata,
	input wire logic s_axi_bvalid,
	input wire logic timer1_on,
	input wire logic codec_if_on,
	input wire logic adc_first_on,
	input wire logic [7:0] capture_on,
	input wire logic [7:0] compare_on,
	input wire logic [3:0] timer6_9_on,
	input wire logic i2c_second_on
);
	// ****
	// read address tracker
	// ****
	logic [PDU_ADDR_W-1:0] ra_r;
	always_ff @(posedge clk) if (s_axi_arvalid && s_axi_arready) ra_r <= s_axi_araddr;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_rst_on; $fell(sys_rst) |-> &capture_on && &compare_on && timer1_on &&
		codec_if_on && adc_first_on && &timer6_9_on && i2c_second_on; endproperty
	a_rst_on: assert property (p_rst_on) else $error("enable low after reset");
	property p_off_lag; !$stable(capture_on) |-> $past(s_axi_bvalid); endproperty
	a_off_lag: assert property (p_off_lag) else $error("enable moved early");
	property p_on_lag; $rose(timer1_on) |-> $past(s_axi_bvalid); endproperty
	a_on_lag: assert property (p_on_lag) else $error("enable rose early");
	property p_map1; $rose(s_axi_rvalid) && ra_r == PDU_OFS_CTRL_1 |->
		timer1_on == !s_axi_rdata[11]; endproperty
	a_map1: assert property (p_map1) else $error("timer1 enable");
	property p_zero1; $rose(s_axi_rvalid) && ra_r == PDU_OFS_CTRL_1 |->
		s_axi_rdata[10:9] == 2'h0 && codec_if_on == !s_axi_rdata[8]; endproperty
	a_zero1: assert property (p_zero1) else $error("codec bits");
	property p_low1; $rose(s_axi_rvalid) && ra_r == PDU_OFS_CTRL_1 |->
		adc_first_on == !s_axi_rdata[0]; endproperty
	a_low1: assert property (p_low1) else $error("adc enable");
	property p_map2; $rose(s_axi_rvalid) && ra_r == PDU_OFS_CTRL_2 |->
		capture_on == ~s_axi_rdata[15:8]; endproperty
	a_map2: assert property (p_map2) else $error("capture enables");
	property p_cmp2; $rose(s_axi_rvalid) && ra_r == PDU_OFS_CTRL_2 |->
		compare_on == ~s_axi_rdata[7:0]; endproperty
	a_cmp2: assert property (p_cmp2) else $error("compare enables");
	property p_map3; $rose(s_axi_rvalid) && ra_r == PDU_OFS_CTRL_3 |->
		timer6_9_on == ~s_axi_rdata[15:12]; endproperty
	a_map3: assert property (p_map3) else $error("timer6 to 9 enables");
	property p_zero3; $rose(s_axi_rvalid) && ra_r == PDU_OFS_CTRL_3 |->
		s_axi_rdata[11:2] == 10'h0 && i2c_second_on == !s_axi_rdata[1]; endproperty
	a_zero3: assert property (p_zero3) else $error("register 3 low bits");
endmodule // pdu_props
bind pdu_top pdu_props u_props (.*);
`default_nettype wire

// ### verification/pdu_periph_model.sv
// Purpose: peripheral fed by a gated clock
// Assumes: en 1 = clocked and writable
// Notes: count and register run on the gated clock only
`timescale 1ns/1ps
`default_nettype none
module pdu_periph_model (
	input wire logic clk,
	input wire logic en,
	input wire logic wr,
	input wire logic [7:0] wd,
	output logic [7:0] q,
	output logic [7:0] cnt
);
	logic en_l;
	logic gclk;
	logic [7:0] c_r = 8'h00;
	logic [7:0] q_r = 8'h00;
	always_latch if (!clk) en_l <= en;
	assign gclk = clk & en_l;
	always @(posedge gclk) begin
		c_r <= c_r + 8'h01;
		if (wr) q_r <= wd;
	end
	assign cnt = c_r;
	assign q = q_r;
endmodule // pdu_periph_model
`default_nettype wire

// ### verification/pdu_top_tb_top.sv
// Purpose: register and enable tests of the disable unit
// Assumes: default present masks
// Notes: ready lines held high throughout
`timescale 1ns/1ps
`default_nettype none
module pdu_top_tb_top
	import pdu_pkg::*;
;
	logic clk = 1'h0, sys_rst = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic s_axi_bready = 1'h1, s_axi_arvalid = 1'h0, s_axi_rready = 1'h1;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic timer5_on, timer4_on, timer3_on, timer2_on, timer1_on, codec_if_on;
	logic i2c_first_on, uart_second_on, uart_first_on, spi_second_on, spi_first_on;
	logic can_second_on, can_first_on, adc_first_on, i2c_second_on, adc_second_on;
	logic [7:0] capture_on, compare_on, per_q, per_cnt, c, pd = 8'h0;
	logic [3:0] timer6_9_on;
	logic pw = 1'h0;
	logic [15:0] m [3] = '{default: 16'h0};
	logic [15:0] msk [3] = '{PDU_IMPL_1, PDU_IMPL_2, PDU_IMPL_3};
	int fail_count = 0, checked = 0, cyc = 0;
	wire [35:0] en_all = {timer5_on, timer4_on, timer3_on, timer2_on, timer1_on,
		codec_if_on, i2c_first_on, uart_second_on, uart_first_on, spi_second_on,
		spi_first_on, can_second_on, can_first_on, adc_first_on, capture_on,
		compare_on, timer6_9_on, i2c_second_on, adc_second_on};
	pdu_top dut (.*);
	pdu_periph_model u_per (.clk(clk), .en(capture_on[0]), .wr(pw), .wd(pd), .q(per_q),
		.cnt(per_cnt));
	always #10 clk = ~clk;
	// ****
	// bus tasks and checks
	// ****
	function automatic logic [35:0] en_exp(input logic [15:0] a, b, d);
		return ~{a[15:11], a[8:0], b, d[15:12], d[1:0]};
	endfunction
	task automatic finish_test;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [35:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s exp %h seen %h", n, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		logic ad, wd;
		ad = 1'h0;
		wd = 1'h0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge clk);
			ad |= s_axi_awready;
			wd |= s_axi_wready;
			s_axi_awvalid <= !ad;
			s_axi_wvalid <= !wd;
		end while (!(ad && wd));
		do @(posedge clk); while (!s_axi_bvalid);
		r = s_axi_bresp;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] q);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge clk); while (!s_axi_rvalid);
		q = s_axi_rdata;
		r = s_axi_rresp;
	endtask
	task automatic rall;
		logic [31:0] q;
		for (int k = 0; k < 3; k++) begin
			rd(4'(4 * k), q);
			chk("reg", q, {16'h0, m[k]});
		end
		rd(4'hc, q);
		chk("unmapped", {q, r}, {32'h0, PDU_RESP_SLVERR});
	endtask
	task automatic wchk(input int k, input logic [15:0] d, input logic [3:0] s);
		logic [35:0] old;
		old = en_exp(m[0], m[1], m[2]);
		if (s[0]) m[k][7:0] = d[7:0];
		if (s[1]) m[k][15:8] = d[15:8];
		m[k] &= msk[k];
		wr(4'(4 * k), {16'hffff, d}, s);
		chk("bresp", r, PDU_RESP_OKAY);
		chk("en early", en_all, old);
		@(posedge clk);
		chk("en", en_all, en_exp(m[0], m[1], m[2]));
		rall();
	endtask
	task automatic do_rst(input int n);
		sys_rst <= 1'h1;
		repeat (n) @(posedge clk);
		sys_rst <= 1'h0;
		m = '{default: 16'h0};
		@(posedge clk);
		chk("en rst", en_all, {36{1'h1}});
		rall();
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			finish_test();
		end
	end
	// ****
	// main sequence
	// ****
	initial begin
		do_rst(8);
		for (int k = 0; k < 3; k++) begin
			for (int i = 0; i < 16; i++)
				wchk(k, 16'(1 << i), 4'h3);
			wchk(k, 16'hffff, 4'h3);
			wchk(k, 16'h0000, 4'h3);
		end
		wchk(1, 16'hffff, 4'h1);
		wchk(1, 16'h0000, 4'h2);
		wr(4'hc, 32'hffffffff, 4'hf);
		chk("bad wr", r, PDU_RESP_SLVERR);
		rall();
		pw <= 1'h1;
		pd <= 8'h5a;
		@(posedge clk);
		pw <= 1'h0;
		@(posedge clk);
		chk("per q", per_q, 8'h5a);
		wchk(1, 16'h0100, 4'h3);
		c = per_cnt;
		pw <= 1'h1;
		pd <= 8'ha5;
		repeat (4) @(posedge clk);
		pw <= 1'h0;
		chk("per stop", per_cnt, c);
		chk("per blk", per_q, 8'h5a);
		wchk(1, 16'h0000, 4'h3);
		chk("per run", per_cnt != c, 1'h1);
		wchk(2, 16'hffff, 4'h3);
		do_rst(2);
		finish_test();
	end
endmodule // pdu_top_tb_top
`default_nettype wire
